// ==== gsr_pkg.sv ====
// constants shared by the gated serial shift register design
// What this block does
// - eight stages, serial in, all stages out
// - clear input acts without waiting for clock
// - any gate input low loads zero
// - one gate high, other decides first stage
// - apart from clear, stages change only on rising clock edge
package gsr_pkg;
	// ----------------------------------------------------------
	// widths
	// ----------------------------------------------------------
	localparam int GSR_STAGES = 8;
	localparam int GSR_SYNC_W = 3;
	// ----------------------------------------------------------
	// bit positions inside the synchroniser bundle
	// ----------------------------------------------------------
	localparam int GSR_BIT_CLK = 0;
	localparam int GSR_BIT_A = 1;
	localparam int GSR_BIT_B = 2;
	// ----------------------------------------------------------
	// stage positions and reset values
	// ----------------------------------------------------------
	localparam int GSR_FIRST = 0;
	localparam int GSR_LAST = GSR_STAGES - 1;
	localparam logic [GSR_STAGES-1:0] GSR_CLEAR_VAL = 8'h00;
	localparam logic [GSR_SYNC_W-1:0] GSR_SYNC_RST = 3'h0;
	localparam logic GSR_BIT_RST = 1'h0;
	localparam logic GSR_LOW = 1'h0;
endpackage

// ==== gsr_sync.sv ====
// two flip-flop synchroniser for the shift clock and gate pin inputs (clear pin is not synchronised)
`timescale 1ns/1ps
module gsr_sync (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// pins in
	input wire logic [gsr_pkg::GSR_SYNC_W-1:0] pin_in,
	// synchronised out
	output logic [gsr_pkg::GSR_SYNC_W-1:0] sync_out
);
	import gsr_pkg::*;

	// ----------------------------------------------------------
	// two stage chain
	// ----------------------------------------------------------
	logic [GSR_SYNC_W-1:0] meta_r;
	logic [GSR_SYNC_W-1:0] meta_nxt;
	logic [GSR_SYNC_W-1:0] sync_r;
	logic [GSR_SYNC_W-1:0] sync_nxt;

	always_comb begin
		meta_nxt = pin_in;
		// first stage is read only by the second
		sync_nxt = meta_r;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= GSR_SYNC_RST;
			sync_r <= GSR_SYNC_RST;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;
endmodule // gsr_sync

// ==== gsr_shift_reg.sv ====
// gated serial-in parallel-out shift register, top level
`timescale 1ns/1ps
module gsr_shift_reg (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// shift clock and clear pins
	input wire logic shift_clk,
	input wire logic clear_n,
	// gated serial inputs
	input wire logic ser_a,
	input wire logic ser_b,
	// parallel outputs
	output logic [gsr_pkg::GSR_STAGES-1:0] par_out
);
	import gsr_pkg::*;

	// ----------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------
	logic [GSR_SYNC_W-1:0] pins_w;
	logic [GSR_SYNC_W-1:0] sync_w;
	logic clk_s;
	logic a_s;
	logic b_s;

	assign pins_w[GSR_BIT_CLK] = shift_clk;
	assign pins_w[GSR_BIT_A] = ser_a;
	assign pins_w[GSR_BIT_B] = ser_b;

	gsr_sync gsr_sync_inst (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(pins_w),
		.sync_out(sync_w)
	);

	assign clk_s = sync_w[GSR_BIT_CLK];
	assign a_s = sync_w[GSR_BIT_A];
	assign b_s = sync_w[GSR_BIT_B];

	// ----------------------------------------------------------
	// shift clock edge detection
	// ----------------------------------------------------------
	logic clk_prev_r;
	logic clk_prev_nxt;
	logic rise_w;

	always_comb begin
		clk_prev_nxt = clk_s;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_prev_r <= GSR_BIT_RST;
		end else begin
			clk_prev_r <= clk_prev_nxt;
		end
	end

	// only the low-to-high transition advances the stages
	assign rise_w = clk_s & ~clk_prev_r;

	// ----------------------------------------------------------
	// gated serial data
	// ----------------------------------------------------------
	logic ser_in_w;

	// gates are looked at only on the detected rise, so changes while
	// the clock is high do not reach the stages
	// a low on either gate yields zero, otherwise the other gate decides
	assign ser_in_w = a_s & b_s;

	// ----------------------------------------------------------
	// shift stages
	// ----------------------------------------------------------
	logic [GSR_STAGES-1:0] stage_r;
	logic [GSR_STAGES-1:0] stage_nxt;
	logic clr_n_w;

	// clear acts straight on the stage flops, independent of any edge
	assign clr_n_w = reset_n & clear_n;

	wire logic [GSR_STAGES-1:0] feed_w;

	// what each stage takes on a detected rise
	genvar gi;
	generate
		for (gi = GSR_FIRST; gi < GSR_STAGES; gi++) begin : g_stage
			if (gi == GSR_FIRST) begin : g_head
				assign feed_w[gi] = ser_in_w;
			end else begin : g_body
				// each later stage takes the old value of the one before
				assign feed_w[gi] = stage_r[gi-1];
			end
		end
	endgenerate

	always_comb begin
		stage_nxt = rise_w ? feed_w : stage_r;
	end

	always_ff @(posedge ref_clk or negedge clr_n_w) begin
		if (!clr_n_w) begin
			stage_r <= GSR_CLEAR_VAL;
		end else begin
			stage_r <= stage_nxt;
		end
	end

	assign par_out = stage_r;

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	property p_clear_low;
		@(posedge ref_clk) disable iff (!reset_n)
		(!clear_n) |-> (par_out == GSR_CLEAR_VAL);
	endproperty
	a_clear_low: assert property (p_clear_low) else $error("outputs not low while clear held");

	property p_gate_low_zero;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && !(a_s && b_s)) |=> (par_out[GSR_FIRST] == GSR_LOW);
	endproperty
	a_gate_low_zero: assert property (p_gate_low_zero) else $error("first stage not zero after gated low");

	property p_gate_pass;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && a_s && clear_n) |=> (!clear_n || (par_out[GSR_FIRST] == $past(b_s)));
	endproperty
	a_gate_pass: assert property (p_gate_pass) else $error("first stage not taken from enabled gate");

	property p_hold_no_edge;
		@(posedge ref_clk) disable iff (!reset_n)
		(!rise_w && clear_n) |=> (!clear_n || $stable(par_out));
	endproperty
	a_hold_no_edge: assert property (p_hold_no_edge) else $error("stages changed without rising edge");

	property p_shift_on;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && clear_n) |=> (!clear_n || (par_out[GSR_LAST:GSR_FIRST+1] == $past(par_out[GSR_LAST-1:GSR_FIRST])));
	endproperty
	a_shift_on: assert property (p_shift_on) else $error("stages did not pass along on edge");

	property p_one_walks;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && a_s && b_s && clear_n) ##1 (clear_n && !rise_w)[*3] ##1 (rise_w && clear_n)
		|=> (!clear_n || par_out[GSR_FIRST+1]);
	endproperty
	a_one_walks: assert property (p_one_walks) else $error("entered one did not reach second stage");

	// ----------------------------------------------------------
	// gate and stage checks
	// ----------------------------------------------------------
	property p_gate_b_pass;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && b_s && clear_n) |=> (!clear_n || (par_out[GSR_FIRST] == $past(a_s)));
	endproperty
	a_gate_b_pass: assert property (p_gate_b_pass) else $error("first stage not taken from gate a");

	property p_both_high_one;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && a_s && b_s && clear_n) |=> (!clear_n || par_out[GSR_FIRST]);
	endproperty
	a_both_high_one: assert property (p_both_high_one) else $error("first stage not one");

	property p_gate_a_low;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && !a_s) |=> (par_out[GSR_FIRST] == GSR_LOW);
	endproperty
	a_gate_a_low: assert property (p_gate_a_low) else $error("gate a low did not block entry");

	property p_last_stage;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && clear_n) |=> (!clear_n || (par_out[GSR_LAST] == $past(par_out[GSR_LAST-1])));
	endproperty
	a_last_stage: assert property (p_last_stage) else $error("last stage not taken from the one before");

	property p_zero_walks;
		@(posedge ref_clk) disable iff (!reset_n)
		(rise_w && !(a_s && b_s) && clear_n) ##1 (clear_n && !rise_w)[*3] ##1 (rise_w && clear_n)
		|=> (!clear_n || !par_out[GSR_FIRST+1]);
	endproperty
	a_zero_walks: assert property (p_zero_walks) else $error("blocked zero did not reach second stage");

	// ----------------------------------------------------------
	// edge and clear checks
	// ----------------------------------------------------------
	property p_fall_ignored;
		@(posedge ref_clk) disable iff (!reset_n)
		(clk_prev_r && !clk_s && clear_n) |=> (!clear_n || $stable(par_out));
	endproperty
	a_fall_ignored: assert property (p_fall_ignored) else $error("stages moved on falling shift clock");

	property p_high_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		(clk_prev_r && clk_s && clear_n) |=> (!clear_n || $stable(par_out));
	endproperty
	a_high_hold: assert property (p_high_hold) else $error("stages moved while shift clock high");

	property p_clear_release;
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(clear_n) |-> (par_out == GSR_CLEAR_VAL);
	endproperty
	a_clear_release: assert property (p_clear_release) else $error("outputs not low as clear ends");

	// ----------------------------------------------------------
	// pin sampling checks
	// ----------------------------------------------------------
	// two flops of latency keep metastable values away from the stages
	property p_sync_clk;
		@(posedge ref_clk) disable iff (!reset_n)
		clk_s == $past(shift_clk, 2);
	endproperty
	a_sync_clk: assert property (p_sync_clk) else $error("shift clock not seen two edges later");

	property p_sync_a;
		@(posedge ref_clk) disable iff (!reset_n)
		a_s == $past(ser_a, 2);
	endproperty
	a_sync_a: assert property (p_sync_a) else $error("gate a not seen two edges later");

	property p_sync_b;
		@(posedge ref_clk) disable iff (!reset_n)
		b_s == $past(ser_b, 2);
	endproperty
	a_sync_b: assert property (p_sync_b) else $error("gate b not seen two edges later");
endmodule // gsr_shift_reg

// ==== gsr_drv.sv ====
// partner model driving the shift clock and gated serial pins
`timescale 1ns/1ps
module gsr_drv (
	// clock
	input wire logic ref_clk,
	// pins out
	output logic shift_clk,
	output logic ser_a,
	output logic ser_b
);
	initial begin
		shift_clk = 1'h0;
		ser_a = 1'h0;
		ser_b = 1'h0;
	end
	// one shift: setup, rise, scramble gates while high, fall
	task automatic shift(input logic a, input logic b);
		@(negedge ref_clk);
		ser_a = a;
		ser_b = b;
		repeat (2) @(negedge ref_clk);
		shift_clk = 1'h1;
		repeat (2) @(negedge ref_clk);
		ser_a = ~a;
		ser_b = ~b;
		repeat (2) @(negedge ref_clk);
		shift_clk = 1'h0;
		repeat (3) @(negedge ref_clk);
	endtask
	// quick shift: rises four cycles apart, two high and two low
	task automatic fast(input logic a, input logic b);
		@(negedge ref_clk);
		ser_a = a;
		ser_b = b;
		@(negedge ref_clk);
		shift_clk = 1'h1;
		repeat (2) @(negedge ref_clk);
		shift_clk = 1'h0;
	endtask
endmodule // gsr_drv

// ==== tb_top.sv ====
// self-checking testbench for the gated shift register
`timescale 1ns/1ps
module tb_top;
	import gsr_pkg::*;
	logic ref_clk, reset_n, clear_n, shift_clk, ser_a, ser_b, chk;
	logic [GSR_STAGES-1:0] par_out, exp_v;
	logic [GSR_STAGES-1:0] exp_q[$];
	logic [1:0] ab_v;
	int fails, n_checks, seed, i;
	gsr_drv gsr_drv_inst (.ref_clk(ref_clk), .shift_clk(shift_clk), .ser_a(ser_a), .ser_b(ser_b));
	gsr_shift_reg gsr_shift_reg_inst (.ref_clk(ref_clk), .reset_n(reset_n), .shift_clk(shift_clk),
		.clear_n(clear_n), .ser_a(ser_a), .ser_b(ser_b), .par_out(par_out));
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ------------------------------------------
	// compare, shift and closing tasks
	// ------------------------------------------
	task automatic check(input logic [GSR_STAGES-1:0] got, input logic [GSR_STAGES-1:0] want);
		n_checks++;
		if (got !== want) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic step(input logic [1:0] v);
		gsr_drv_inst.shift(v[1], v[0]);
		exp_v = {exp_v[GSR_STAGES-2:0], v[1] & v[0]};
		exp_q.push_back(exp_v);
		chk = 1'h1;
		@(negedge ref_clk);
		chk = 1'h0;
	endtask
	task automatic complete_run;
		if (exp_q.size() > 0) fails++;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// monitor takes the oldest note when a shift result is flagged
	always @(posedge ref_clk) begin
		if (chk === 1'h1 && exp_q.size() > 0) check(par_out, exp_q.pop_front());
	end
	initial begin
		#100000;
		fails++;
		complete_run();
	end
	// ------------------------------------------
	// main sequence
	// ------------------------------------------
	initial begin
		seed = 32'h4c35;
		reset_n = 1'h0;
		clear_n = 1'h1;
		chk = 1'h0;
		fails = 0;
		n_checks = 0;
		exp_v = GSR_CLEAR_VAL;
		repeat (5) @(negedge ref_clk);
		check(par_out, GSR_CLEAR_VAL);
		reset_n = 1'h1;
		for (i = 0; i < 4; i++) step(i[1:0]);
		$display("test gate combinations done");
		for (i = 0; i < 32; i++) step(i < 8 ? 2'h3 : 2'($random(seed)));
		$display("test random shifts done");
		for (i = 0; i < GSR_STAGES; i++) begin
			ab_v = i[0] ? 2'($random(seed)) : (i[1] ? 2'h2 : 2'h3);
			gsr_drv_inst.fast(ab_v[1], ab_v[0]);
			exp_v = {exp_v[GSR_STAGES-2:0], ab_v[1] & ab_v[0]};
		end
		@(negedge ref_clk);
		exp_q.push_back(exp_v);
		chk = 1'h1;
		@(negedge ref_clk);
		chk = 1'h0;
		$display("test fast shifts done");
		step(2'h3);
		@(negedge ref_clk);
		clear_n = 1'h0;
		#1;
		check(par_out, GSR_CLEAR_VAL);
		exp_v = GSR_CLEAR_VAL;
		@(negedge ref_clk);
		clear_n = 1'h1;
		for (i = 0; i < 4; i++) step(2'h3);
		$display("test clear done");
		complete_run();
	end
endmodule // tb_top
